// >>> hdl/port_drive_level_select.v
/*
 Port drive-level select bank: AHB-Lite slave holding the source-current
 level registers and the port E supply select. Assumes one AHB master, word
 transfers, and analogue pad drivers fed from the level outputs.
*/
`timescale 1ns/100ps
`default_nettype none
`include "drive_level_defs.vh"

module port_drive_level_select
#(
	parameter HAS_PORTS_G_H = 1
)
(
	input wire mclk,
	input wire arst_n,
	input wire hsel,
	input wire [31:0] haddr,
	input wire [1:0] htrans,
	input wire hwrite,
	input wire [2:0] hsize,
	input wire [31:0] hwdata,
	input wire hready,
	output reg [31:0] hrdata,
	output reg hreadyout,
	output reg hresp,
	output reg [1:0] port_a_lo_level,
	output reg [1:0] port_a_hi_level,
	output reg [1:0] port_b_lo_level,
	output reg [1:0] port_b_hi_level,
	output reg [1:0] port_c_lo_level,
	output reg [1:0] port_c_hi_level,
	output reg [1:0] port_d_lo_level,
	output reg [1:0] port_d_hi_level,
	output reg [1:0] port_e_lo_level,
	output reg [1:0] port_e_pin4_level,
	output reg [1:0] port_f_lo_level,
	output reg [1:0] port_f_hi_level,
	output reg [1:0] port_g_lo_level,
	output reg [1:0] port_g_hi_level,
	output reg [1:0] port_h_lo_level,
	output reg [1:0] port_h_hi_level,
	output reg port_e_from_io_supply
);

	// ----------------------------------------
	// Storage
	// ----------------------------------------
	reg [7:0] drive_level_ports_a_b;
	reg [7:0] drive_level_ports_c_d;
	reg [7:0] drive_level_ports_e_f;
	reg [7:0] drive_level_ports_g_h;
	reg [1:0] port_e_supply_select_field;

	reg wr_pend_r;
	reg [4:0] wr_sel_r;

	wire has_gh;
	wire [4:0] addr_sel;
	wire xfer;
	wire [1:0] ab0, ab1, ab2, ab3;
	wire [1:0] cd0, cd1, cd2, cd3;
	wire [1:0] ef0, ef1, ef2, ef3;
	wire [1:0] gh0, gh1, gh2, gh3;
	reg [31:0] rd_nxt;

	assign has_gh = (HAS_PORTS_G_H != 0);
	assign xfer = hsel && hready && (htrans == `HTRANS_NONSEQ || htrans == `HTRANS_SEQ);

	drive_addr_decode u_decode
	(
		.addr(haddr[7:0]),
		.has_gh(has_gh),
		.sel(addr_sel)
	);

	// ----------------------------------------
	// Read mux
	// ----------------------------------------
	always @*
	begin
		rd_nxt = 32'h0000_0000;
		case (addr_sel)
			5'h01: rd_nxt = {24'h00_0000, drive_level_ports_a_b};
			5'h02: rd_nxt = {24'h00_0000, drive_level_ports_c_d};
			5'h04: rd_nxt = {24'h00_0000, drive_level_ports_e_f};
			5'h08: rd_nxt = {24'h00_0000, drive_level_ports_g_h};
			5'h10: rd_nxt = {30'h0000_0000, port_e_supply_select_field};
			default: rd_nxt = 32'h0000_0000;
		endcase
	end

	// ----------------------------------------
	// AHB-Lite slave, zero wait states
	// ----------------------------------------
	// Unmapped and absent addresses read zero, ignore writes, answer OKAY
	always @(posedge mclk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			wr_pend_r <= 1'b0;
			wr_sel_r <= 5'h00;
			hrdata <= 32'h0000_0000;
			hreadyout <= 1'b1;
			hresp <= `HRESP_OKAY;
		end
		else
		begin
			hreadyout <= 1'b1;
			hresp <= `HRESP_OKAY;
			wr_pend_r <= xfer && hwrite;
			wr_sel_r <= addr_sel;
			if (xfer && !hwrite)
				hrdata <= rd_nxt;
		end
	end

	// Write lands in the data phase, once hwdata is valid
	always @(posedge mclk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			drive_level_ports_a_b <= `DRIVE_RESET;
			drive_level_ports_c_d <= `DRIVE_RESET;
			drive_level_ports_e_f <= `DRIVE_RESET;
			drive_level_ports_g_h <= `DRIVE_RESET;
			port_e_supply_select_field <= `SUPPLY_RESET;
		end
		else if (wr_pend_r)
		begin
			if (wr_sel_r[0])
				drive_level_ports_a_b <= hwdata[7:0];
			if (wr_sel_r[1])
				drive_level_ports_c_d <= hwdata[7:0];
			if (wr_sel_r[2])
				drive_level_ports_e_f <= hwdata[7:0];
			if (wr_sel_r[3])
				drive_level_ports_g_h <= hwdata[7:0];
			if (wr_sel_r[4])
				port_e_supply_select_field <= hwdata[1:0];
		end
	end

	// ----------------------------------------
	// Field split per register
	// ----------------------------------------
	drive_field_split u_ab
	(
		.value(drive_level_ports_a_b),
		.lo_grp0(ab0),
		.lo_grp1(ab1),
		.hi_grp0(ab2),
		.hi_grp1(ab3)
	);

	drive_field_split u_cd
	(
		.value(drive_level_ports_c_d),
		.lo_grp0(cd0),
		.lo_grp1(cd1),
		.hi_grp0(cd2),
		.hi_grp1(cd3)
	);

	drive_field_split u_ef
	(
		.value(drive_level_ports_e_f),
		.lo_grp0(ef0),
		.lo_grp1(ef1),
		.hi_grp0(ef2),
		.hi_grp1(ef3)
	);

	drive_field_split u_gh
	(
		.value(drive_level_ports_g_h),
		.lo_grp0(gh0),
		.lo_grp1(gh1),
		.hi_grp0(gh2),
		.hi_grp1(gh3)
	);

	// ----------------------------------------
	// Registered pad controls
	// ----------------------------------------
	// Pads see the new level one cycle after the register updates
	always @(posedge mclk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			port_a_lo_level <= 2'h0;
			port_a_hi_level <= 2'h0;
			port_b_lo_level <= 2'h0;
			port_b_hi_level <= 2'h0;
			port_c_lo_level <= 2'h0;
			port_c_hi_level <= 2'h0;
			port_d_lo_level <= 2'h0;
			port_d_hi_level <= 2'h0;
			port_e_lo_level <= 2'h0;
			port_e_pin4_level <= 2'h0;
			port_f_lo_level <= 2'h0;
			port_f_hi_level <= 2'h0;
			port_g_lo_level <= 2'h0;
			port_g_hi_level <= 2'h0;
			port_h_lo_level <= 2'h0;
			port_h_hi_level <= 2'h0;
			port_e_from_io_supply <= `SUPPLY_MAIN;
		end
		else
		begin
			port_a_lo_level <= ab0;
			port_a_hi_level <= ab1;
			port_b_lo_level <= ab2;
			port_b_hi_level <= ab3;
			port_c_lo_level <= cd0;
			port_c_hi_level <= cd1;
			port_d_lo_level <= cd2;
			port_d_hi_level <= cd3;
			port_e_lo_level <= ef0;
			port_e_pin4_level <= ef1;
			port_f_lo_level <= ef2;
			port_f_hi_level <= ef3;
			port_g_lo_level <= gh0;
			port_g_hi_level <= gh1;
			port_h_lo_level <= gh2;
			port_h_hi_level <= gh3;
			// Only the upper bit matters; relies on software having set up the pin first
			port_e_from_io_supply <= port_e_supply_select_field[`SUPPLY_FLD_MSB];
		end
	end

endmodule
`default_nettype wire

// >>> pkg/drive_level_defs.vh
/*
 Register offsets, field positions and reset values for the port drive-level
 select bank. Assumes inclusion by the AHB-Lite register block and its helpers.
*/
`ifndef DRIVE_LEVEL_DEFS_VH
`define DRIVE_LEVEL_DEFS_VH

// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define OFS_DRIVE_AB 8'h00
`define OFS_DRIVE_CD 8'h04
`define OFS_DRIVE_EF 8'h08
`define OFS_DRIVE_GH 8'h0C
`define OFS_SUPPLY_SEL 8'h10

// ----------------------------------------
// Field positions and reset values
// ----------------------------------------
`define FLD_LO0 1
`define FLD_LO1 3
`define FLD_HI0 5
`define FLD_HI1 7
`define SUPPLY_FLD_MSB 1
`define DRIVE_RESET 8'h00
`define SUPPLY_RESET 2'h0
`define SUPPLY_MAIN 1'b0
`define SUPPLY_IO_PIN 1'b1

// ----------------------------------------
// AHB encodings
// ----------------------------------------
`define HTRANS_NONSEQ 2'h2
`define HTRANS_SEQ 2'h3
`define HRESP_OKAY 1'b0

`endif

// >>> hdl/drive_addr_decode.v
/*
 Address decoder for the drive-level bank: turns a byte address into a
 one-hot register select. Assumes word-aligned AHB addresses.
*/
`timescale 1ns/100ps
`default_nettype none
`include "drive_level_defs.vh"

module drive_addr_decode
(
	input wire [7:0] addr,
	input wire has_gh,
	output reg [4:0] sel
);

	always @*
	begin
		sel = 5'h00;
		case (addr)
			`OFS_DRIVE_AB: sel = 5'h01;
			`OFS_DRIVE_CD: sel = 5'h02;
			`OFS_DRIVE_EF: sel = 5'h04;
			`OFS_DRIVE_GH: sel = has_gh ? 5'h08 : 5'h00;
			`OFS_SUPPLY_SEL: sel = 5'h10;
			default: sel = 5'h00;
		endcase
	end

endmodule
`default_nettype wire

// >>> hdl/drive_field_split.v
/*
 Splits one eight-bit drive register into its four two-bit level codes.
 Assumes the register holds the codes low group first.
*/
`timescale 1ns/100ps
`default_nettype none
`include "drive_level_defs.vh"

module drive_field_split
(
	input wire [7:0] value,
	output wire [1:0] lo_grp0,
	output wire [1:0] lo_grp1,
	output wire [1:0] hi_grp0,
	output wire [1:0] hi_grp1
);

	// Code 00 weakest through 11 strongest, passed unchanged
	assign lo_grp0 = value[`FLD_LO0 -: 2];
	assign lo_grp1 = value[`FLD_LO1 -: 2];
	assign hi_grp0 = value[`FLD_HI0 -: 2];
	assign hi_grp1 = value[`FLD_HI1 -: 2];

endmodule
`default_nettype wire

// >>> tb/drive_level_chk.sv
/*
 Port checker for the drive-level bank.
 Assumes hready is tied to hreadyout.
*/
`timescale 1ns/100ps
`default_nettype none
module drive_level_chk
#(
	parameter HAS_PORTS_G_H = 1
)
(
	input wire mclk,
	input wire arst_n,
	input wire hsel,
	input wire [31:0] haddr,
	input wire [1:0] htrans,
	input wire hwrite,
	input wire [31:0] hwdata,
	input wire hready,
	input wire [31:0] hrdata,
	input wire [1:0] port_a_lo_level,
	input wire [1:0] port_d_hi_level,
	input wire [1:0] port_e_pin4_level,
	input wire [1:0] port_h_hi_level,
	input wire port_e_from_io_supply
);
// ----
// Transfer decode
// ----
wire wr = hsel && hready && htrans[1] && hwrite;
wire rd = hsel && hready && htrans[1] && !hwrite;
wire wr_ab = wr && haddr[7:0] == 8'h00;
wire wr_cd = wr && haddr[7:0] == 8'h04;
wire wr_ef = wr && haddr[7:0] == 8'h08;
wire wr_gh = wr && haddr[7:0] == 8'h0C && HAS_PORTS_G_H != 0;
wire wr_sup = wr && haddr[7:0] == 8'h10;
default clocking @(posedge mclk); endclocking
default disable iff (!arst_n);
// ----
// Properties
// ----
a_lo_write_a: assert property (wr_ab |=> ##2 port_a_lo_level == $past(hwdata[1:0], 2))
	else $error("port a low level not loaded");
d_hi_write_a: assert property (wr_cd |=> ##2 port_d_hi_level == $past(hwdata[7:6], 2))
	else $error("port d high level not loaded");
e_pin4_write_a: assert property (wr_ef |=> ##2 port_e_pin4_level == $past(hwdata[3:2], 2))
	else $error("port e pin4 level not loaded");
h_hi_write_a: assert property (wr_gh |=> ##2 port_h_hi_level == $past(hwdata[7:6], 2))
	else $error("port h high level not loaded");
supply_bit_a: assert property (wr_sup |=> ##2 port_e_from_io_supply == $past(hwdata[1], 2))
	else $error("supply select not taken from bit 1");
supply_read_a: assert property (rd && haddr[7:0] == 8'h10 |=> hrdata[31:2] == 30'h0)
	else $error("supply register upper bits not zero");
a_lo_hold_a: assert property ($changed(port_a_lo_level) |-> $past(wr_ab, 3))
	else $error("port a low level moved without write");
supply_hold_a: assert property ($changed(port_e_from_io_supply) |-> $past(wr_sup, 3))
	else $error("supply select moved without write");
endmodule
`default_nettype wire

// >>> tb/test_port_drive_level_select.sv
/*
 Bench for the drive-level bank: AHB-Lite reads and writes with expected values.
 Assumes zero-wait slave, hready tied to hreadyout.
*/
`timescale 1ns/100ps
`default_nettype none
module test_port_drive_level_select;
logic mclk = 1'b0;
logic arst_n = 1'b0;
logic hsel = 1'b0;
logic [31:0] haddr = 32'h0;
logic [1:0] htrans = 2'h0;
logic hwrite = 1'b0;
logic [2:0] hsize = 3'h2;
logic [31:0] hwdata = 32'h0;
logic [31:0] hrdata;
logic [31:0] q;
logic hreadyout;
logic hresp;
logic port_e_from_io_supply;
logic [1:0] a_lo, a_hi, b_lo, b_hi, c_lo, c_hi, d_lo, d_hi;
logic [1:0] e_lo, e_p4, f_lo, f_hi, g_lo, g_hi, h_lo, h_hi;
logic [31:0] small_rd;
logic small_rdy;
wire [7:0] small_gh;
// Every field nonzero somewhere so the level assertions can trip
logic [7:0] pat [4] = '{8'h1B, 8'hE4, 8'h4E, 8'hB1};
int fails = 0;
int comparisons = 0;
port_drive_level_select #(.HAS_PORTS_G_H(1)) DUT (.mclk(mclk), .arst_n(arst_n), .hsel(hsel), .haddr(haddr),
	.htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
	.hreadyout(hreadyout), .hresp(hresp), .port_a_lo_level(a_lo), .port_a_hi_level(a_hi),
	.port_b_lo_level(b_lo), .port_b_hi_level(b_hi), .port_c_lo_level(c_lo), .port_c_hi_level(c_hi),
	.port_d_lo_level(d_lo), .port_d_hi_level(d_hi), .port_e_lo_level(e_lo), .port_e_pin4_level(e_p4),
	.port_f_lo_level(f_lo), .port_f_hi_level(f_hi), .port_g_lo_level(g_lo), .port_g_hi_level(g_hi),
	.port_h_lo_level(h_lo), .port_h_hi_level(h_hi), .port_e_from_io_supply(port_e_from_io_supply));
// Smallest variant on the same bus: no fourth drive register
port_drive_level_select #(.HAS_PORTS_G_H(0)) dut_small (.mclk(mclk), .arst_n(arst_n), .hsel(hsel),
	.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(small_rdy),
	.hrdata(small_rd), .hreadyout(small_rdy), .hresp(), .port_a_lo_level(), .port_a_hi_level(),
	.port_b_lo_level(), .port_b_hi_level(), .port_c_lo_level(), .port_c_hi_level(),
	.port_d_lo_level(), .port_d_hi_level(), .port_e_lo_level(), .port_e_pin4_level(),
	.port_f_lo_level(), .port_f_hi_level(), .port_g_lo_level(small_gh[1:0]), .port_g_hi_level(small_gh[3:2]),
	.port_h_lo_level(small_gh[5:4]), .port_h_hi_level(small_gh[7:6]), .port_e_from_io_supply());
initial
	forever #5 mclk = ~mclk;
// ----
// Bus tasks
// ----
task check(input [31:0] seen, input [31:0] exp);
	comparisons = comparisons + 1;
	if (seen !== exp)
	begin
		fails = fails + 1;
		$display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
	end
endtask
task results;
	$display("comparisons %0d fails %0d", comparisons, fails);
	if (fails == 0 && comparisons > 0)
		$display("Finished cleanly");
	else
		$display("Finished with errors");
	$finish;
endtask
// Bounded wait for an edge with hready high
task ready_edge;
	int n;
	n = 0;
	@(posedge mclk);
	while (hreadyout !== 1'b1)
	begin
		n = n + 1;
		if (n > 20)
		begin
			fails = fails + 1;
			results;
		end
		@(posedge mclk);
	end
endtask
task xfer(input [7:0] a, input w, input [31:0] d, output [31:0] r);
	hsel <= 1'b1;
	haddr <= {24'h000000, a};
	hwrite <= w;
	htrans <= 2'h2;
	ready_edge;
	htrans <= 2'h0;
	hsel <= 1'b0;
	hwdata <= d;
	ready_edge;
	r = hrdata;
endtask
// ----
// Sequence
// ----
initial
begin
	repeat (16) @(posedge mclk);
	arst_n <= 1'b1;
	for (int i = 0; i < 5; i++)
	begin
		xfer(8'(i * 4), 1'b0, 32'h0, q);
		check(q, 32'h0);
		check({hreadyout, hresp}, 32'h2);
	end
	// Upper bytes set so stray storage shows up
	for (int i = 0; i < 4; i++)
	begin
		xfer(8'(i * 4), 1'b1, {24'hFFFFFF, pat[i]}, q);
		xfer(8'(i * 4), 1'b0, 32'h0, q);
		check(q, {24'h0, pat[i]});
		check(small_rd, (i == 3) ? 32'h0 : {24'h0, pat[i]});
	end
	check({b_hi, b_lo, a_hi, a_lo}, 32'h1B);
	check({d_hi, d_lo, c_hi, c_lo}, 32'hE4);
	check({f_hi, f_lo, e_p4, e_lo}, 32'h4E);
	check({h_hi, h_lo, g_hi, g_lo}, 32'hB1);
	check(small_gh, 32'h0);
	// I/O supply pin function taken as already assigned by software
	for (int i = 3; i >= 0; i--)
	begin
		xfer(8'h10, 1'b1, {30'h0000003F, 2'(i)}, q);
		xfer(8'h10, 1'b0, 32'h0, q);
		check(q, 32'(i));
		check(port_e_from_io_supply, 32'(i / 2));
	end
	xfer(8'h14, 1'b1, 32'hFF, q);
	xfer(8'h14, 1'b0, 32'h0, q);
	check(q, 32'h0);
	// Mid-run reset must bring loaded fields back to the weakest code
	arst_n <= 1'b0;
	@(posedge mclk);
	arst_n <= 1'b1;
	xfer(8'h04, 1'b0, 32'h0, q);
	check(q, 32'h0);
	check({b_hi, b_lo, a_hi, a_lo}, 32'h0);
	check({d_hi, d_lo, c_hi, c_lo}, 32'h0);
	results;
end
endmodule
bind port_drive_level_select drive_level_chk #(.HAS_PORTS_G_H(HAS_PORTS_G_H)) chk (.mclk(mclk), .arst_n(arst_n),
	.hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata), .hready(hready),
	.hrdata(hrdata), .port_a_lo_level(port_a_lo_level), .port_d_hi_level(port_d_hi_level),
	.port_e_pin4_level(port_e_pin4_level), .port_h_hi_level(port_h_hi_level),
	.port_e_from_io_supply(port_e_from_io_supply));
`default_nettype wire
